// >>> design/sfe_front_end.sv
// Serial flash SPI front end: pin sampling, command decode, array requests.
`timescale 1ns/1ps
`default_nettype none

module sfe_front_end
   import sfe_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire sfe_pins_t pins, // Raw pins from the master.
   input wire logic core_busy, // Array core has a cycle running.
   input wire logic [7:0] core_rdata, // Byte returned by the array core.
   output logic miso_o, // Serial output value.
   output logic miso_oe_n, // Low while the device drives its output.
   output sfe_req_t req, // Requests to the array core.
   output logic active_pwr, // High in the active power state.
   output logic standby // High in standby.
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Two sync flops for every pin; logic reads the second stage and the third copy.
   sfe_pins_t s1_r, s2_r, s3_r;

   // First and second stage, plus a third copy used for edge finding.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // Select resets low in every stage. A select that is held low
         // through reset must not look like the arming edge; the cost
         // is that active power reads high until the pin has passed.
         s1_r <= '{sclk: 1'b0, sel_n: 1'b0, pause_n: 1'b1, mosi: 1'b0};
         s2_r <= '{sclk: 1'b0, sel_n: 1'b0, pause_n: 1'b1, mosi: 1'b0};
         s3_r <= '{sclk: 1'b0, sel_n: 1'b0, pause_n: 1'b1, mosi: 1'b0};
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Edge detectors on the synchronised pins.
   logic rise, fall, sel_fall;
   assign rise = s2_r.sclk & ~s3_r.sclk;
   assign fall = ~s2_r.sclk & s3_r.sclk;
   assign sel_fall = ~s2_r.sel_n & s3_r.sel_n;

   // ****************************************************************
   // Command engine
   // ****************************************************************
   sfe_state_t st_r, st_nxt;
   logic armed_r, armed_nxt; // Select edge seen since reset.
   logic paused_r, paused_nxt; // Pause condition in force.
   logic [7:0] sh_r, sh_nxt; // Input shift register.
   logic [2:0] bit_r, bit_nxt; // Bits received in current byte.
   logic [1:0] abyte_r, abyte_nxt; // Address bytes received.
   logic [7:0] op_r, op_nxt; // Opcode of current command.
   logic [SFE_ADDR_W-1:0] addr_r, addr_nxt; // Running address.
   logic [8:0] wcnt_r, wcnt_nxt; // Bytes accepted in a page write.
   logic [7:0] osh_r, osh_nxt; // Output shift register.
   logic miso_r, miso_nxt; // Registered serial output.
   logic oe_n_r, oe_n_nxt; // Registered output enable.
   sfe_req_t req_r, req_nxt;
   logic [7:0] byte_in;

   // Next page address wraps inside the page, sector bits are kept.
   function automatic logic [SFE_ADDR_W-1:0] page_inc(
      input logic [SFE_ADDR_W-1:0] a);
      page_inc = {a[SFE_ADDR_W-1:SFE_PAGE_LSB],
                  a[SFE_PAGE_LSB-1:0] + 8'h01};
   endfunction : page_inc

   assign byte_in = {sh_r[6:0], s2_r.mosi};

   // Next state of the whole command engine.
   always_comb begin
      st_nxt = st_r;
      armed_nxt = armed_r;
      paused_nxt = paused_r;
      sh_nxt = sh_r;
      bit_nxt = bit_r;
      abyte_nxt = abyte_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      wcnt_nxt = wcnt_r;
      osh_nxt = osh_r;
      miso_nxt = miso_r;
      oe_n_nxt = oe_n_r;
      req_nxt = '0;
      req_nxt.addr = addr_r;
      req_nxt.wdata = req_r.wdata;
      if (sel_fall) begin
         armed_nxt = 1'b1;
      end
      if (s2_r.sel_n) begin
         // Deselected: abandon any partial command; only a finished erase
         // is issued now, since page write bytes already went out one by one.
         if (st_r == SFE_ST_WIPE && bit_r == 3'd0) begin
            req_nxt.wipe_all = (op_r == SFE_OP_FULL_WIPE);
            req_nxt.wipe_sect = (op_r == SFE_OP_BLOCK_WIPE);
         end
         st_nxt = SFE_ST_IDLE;
         paused_nxt = 1'b0;
         bit_nxt = 3'd0;
         abyte_nxt = 2'd0;
         wcnt_nxt = 9'd0;
         oe_n_nxt = 1'b1;
      end else if (!s2_r.pause_n && !paused_r && s2_r.sclk == 1'b0) begin
         // Pause starts only while selected and clock low.
         paused_nxt = 1'b1;
         oe_n_nxt = 1'b1;
      end else if (paused_r) begin
         // Clock and data ignored until pause is released.
         if (s2_r.pause_n && s2_r.sclk == 1'b0) begin
            paused_nxt = 1'b0;
            oe_n_nxt = (st_r == SFE_ST_RDATA) ? 1'b0 : 1'b1;
         end
      end else if (armed_r && rise) begin
         // Sample on rising edges, either clock idle level.
         sh_nxt = byte_in;
         bit_nxt = bit_r + 3'd1;
         if (bit_r == 3'd7) begin
            case (st_r)
               SFE_ST_IDLE: begin
                  op_nxt = byte_in;
                  abyte_nxt = 2'd0;
                  if (byte_in == SFE_OP_FULL_WIPE)
                     st_nxt = SFE_ST_WIPE;
                  else if (byte_in == SFE_OP_PAGE_WRITE ||
                           byte_in == SFE_OP_READ ||
                           byte_in == SFE_OP_BLOCK_WIPE)
                     st_nxt = SFE_ST_ADDR;
                  else
                     st_nxt = SFE_ST_DONE;
               end
               SFE_ST_ADDR: begin
                  addr_nxt = {addr_r[SFE_ADDR_W-9:0], byte_in};
                  abyte_nxt = abyte_r + 2'd1;
                  if (abyte_r == 2'(SFE_ADDR_BYTES - 1)) begin
                     if (op_r == SFE_OP_PAGE_WRITE) begin
                        st_nxt = SFE_ST_WDATA;
                     end else if (op_r == SFE_OP_BLOCK_WIPE) begin
                        st_nxt = SFE_ST_WIPE;
                     end else begin
                        st_nxt = SFE_ST_RDATA;
                        req_nxt.rd = 1'b1;
                        req_nxt.addr = {addr_r[SFE_ADDR_W-9:0], byte_in};
                     end
                  end
               end
               SFE_ST_WDATA: begin
                  // Bytes past the page size are dropped.
                  if (wcnt_r < 9'(SFE_MAX_WRITE)) begin
                     req_nxt.wr = 1'b1;
                     req_nxt.wdata = byte_in;
                     addr_nxt = page_inc(addr_r);
                     wcnt_nxt = wcnt_r + 9'd1;
                  end
               end
               SFE_ST_RDATA: begin
                  addr_nxt = addr_r + 18'h00001;
                  req_nxt.rd = 1'b1;
                  req_nxt.addr = addr_r + 18'h00001;
               end
               SFE_ST_WIPE: begin
                  st_nxt = SFE_ST_DONE; // Extra bytes cancel the erase.
               end
               SFE_ST_DONE: begin
                  st_nxt = SFE_ST_DONE;
               end
               default: begin
                  st_nxt = SFE_ST_DONE;
               end
            endcase
         end
      end else if (armed_r && fall && st_r == SFE_ST_RDATA) begin
         // Shift out on falling edges, most significant bit first.
         if (bit_r == 3'd0) begin
            miso_nxt = core_rdata[7];
            osh_nxt = {core_rdata[6:0], 1'b0};
         end else begin
            miso_nxt = osh_r[7];
            osh_nxt = {osh_r[6:0], 1'b0};
         end
         oe_n_nxt = 1'b0;
      end
   end

   // Register the command engine.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= SFE_ST_IDLE;
         armed_r <= 1'b0;
         paused_r <= 1'b0;
         sh_r <= 8'h00;
         bit_r <= 3'd0;
         abyte_r <= 2'd0;
         op_r <= 8'h00;
         addr_r <= '0;
         wcnt_r <= 9'd0;
         osh_r <= 8'h00;
         miso_r <= 1'b0;
         oe_n_r <= 1'b1;
         req_r <= '0;
      end else begin
         st_r <= st_nxt;
         armed_r <= armed_nxt;
         paused_r <= paused_nxt;
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         abyte_r <= abyte_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         wcnt_r <= wcnt_nxt;
         osh_r <= osh_nxt;
         miso_r <= miso_nxt;
         oe_n_r <= oe_n_nxt;
         req_r <= req_nxt;
      end
   end

   // ****************************************************************
   // Outputs and power state
   // ****************************************************************
   assign miso_o = miso_r;
   assign miso_oe_n = oe_n_r;
   assign req = req_r;
   // Selected or busy keeps active power; otherwise standby.
   assign active_pwr = ~s2_r.sel_n | core_busy;
   assign standby = ~active_pwr;

endmodule : sfe_front_end

`default_nettype wire

// >>> design/sfe_pkg.sv
// Package with constants and types for the serial flash front end.
package sfe_pkg;

   // ****************************************************************
   // Array organisation
   // ****************************************************************
   localparam int SFE_SECTORS = 4; // Sectors in the array.
   localparam int SFE_PAGES_PER_SECTOR = 256; // Pages in each sector.
   localparam int SFE_PAGE_BYTES = 256; // Bytes in each page.
   localparam int SFE_ADDR_W = 18; // Byte address width, 4*256*256 bytes.
   localparam int SFE_SECT_LSB = 16; // Lowest sector bit of the address.
   localparam int SFE_PAGE_LSB = 8; // Lowest page bit of the address.
   localparam int SFE_BYTE_BITS = 8; // Bits in one serial byte.
   localparam int SFE_MAX_WRITE = 256; // Most bytes in one page write.
   localparam int SFE_ADDR_BYTES = 3; // Address bytes after an opcode.

   // ****************************************************************
   // Command codes, arbitrary values chosen for this block
   // ****************************************************************
   localparam logic [7:0] SFE_OP_PAGE_WRITE = 8'h02; // Page write.
   localparam logic [7:0] SFE_OP_READ = 8'h03; // Plain read.
   localparam logic [7:0] SFE_OP_BLOCK_WIPE = 8'hd8; // Sector erase.
   localparam logic [7:0] SFE_OP_FULL_WIPE = 8'hc7; // Whole array erase.

   // ****************************************************************
   // Types
   // ****************************************************************
   // Command phase state machine.
   typedef enum logic [2:0] {
      SFE_ST_IDLE = 3'b000,
      SFE_ST_ADDR = 3'b001,
      SFE_ST_WDATA = 3'b010,
      SFE_ST_RDATA = 3'b011,
      SFE_ST_WIPE = 3'b100,
      SFE_ST_DONE = 3'b101
   } sfe_state_t;

   // Pins seen from the master side.
   typedef struct packed {
      logic sclk; // Serial clock.
      logic sel_n; // Device select, active low.
      logic pause_n; // Pause request, active low.
      logic mosi; // Serial data into the device.
   } sfe_pins_t;

   // Request to the flash array core.
   typedef struct packed {
      logic wr; // Write one byte, one cycle pulse.
      logic rd; // Read one byte, one cycle pulse.
      logic wipe_sect; // Sector erase pulse.
      logic wipe_all; // Full array erase pulse.
      logic [SFE_ADDR_W-1:0] addr; // Byte address or sector.
      logic [7:0] wdata; // Byte to program.
   } sfe_req_t;

endpackage : sfe_pkg

// >>> tb/sfe_spi_master.sv
// SPI bus master model that drives the flash front end pins.
`timescale 1ns/1ps
`default_nettype none

module sfe_spi_master
   import sfe_pkg::*;
(
   input wire logic ref_clk,
   input wire logic miso_o,
   input wire logic miso_oe_n,
   output var sfe_pins_t pins
);
   // A released output reads as the inverse of its last value.
   wire logic line = miso_oe_n ? ~miso_o : miso_o;
   logic cpol = 1'b0; // Clock idle level of the frame.

   // Select is low from power-up, so the first frame has no falling edge.
   initial pins = 4'h2;

   // Wait n falling edges; eight of them make half a 64 ns period.
   task automatic hold(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : hold

   // Open a frame with the clock resting at its idle level.
   task automatic start(input logic pol);
      cpol = pol;
      pins.sclk = pol;
      hold(8);
      pins.sel_n = 1'b0;
      hold(8);
   endtask : start

   // Close the frame; the data line then wanders.
   task automatic stop();
      pins.sclk = cpol;
      hold(8);
      pins.sel_n = 1'b1;
      pins.mosi = ~pins.mosi;
      hold(8);
   endtask : stop

   // One byte, MSB first; a pause at bit pb wiggles clock and data.
   task automatic xfer(input logic [7:0] b, input int pb,
                       output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         pins.sclk = 1'b0;
         pins.mosi = b[i];
         hold(8);
         if (i == pb) begin
            // Pause begins with the clock low and selected, and the
            // clock rests until the device has taken the pause in.
            pins.pause_n = 1'b0;
            hold(4);
            repeat (4) begin
               pins.sclk = ~pins.sclk;
               pins.mosi = ~pins.mosi;
               hold(4);
            end
            pins.mosi = b[i];
            hold(4);
            pins.pause_n = 1'b1;
            hold(8);
         end
         pins.sclk = 1'b1;
         hold(8);
         r[i] = line;
      end
   endtask : xfer
endmodule : sfe_spi_master

`default_nettype wire

// >>> tb/sfe_front_end_chk.sv
// Port checks for the flash front end.
`timescale 1ns/1ps
`default_nettype none

module sfe_front_end_chk
   import sfe_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire sfe_pins_t pins,
   input wire logic core_busy,
   input wire logic miso_o,
   input wire logic miso_oe_n,
   input wire sfe_req_t req,
   input wire logic active_pwr,
   input wire logic standby
);
   // Pins cross a two-flop sync, so windows allow some cycles of lag.
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   AST_DESEL_HIZ: assert property (pins.sel_n [*5] |-> miso_oe_n)
      else $error("output driven while deselected");
   AST_PAUSE_HIZ: assert property ((!pins.pause_n) [*5]
      |-> miso_oe_n)
      else $error("output driven while paused");
   AST_SEL_ACTIVE: assert property ((!pins.sel_n) [*4]
      |-> active_pwr)
      else $error("selected but not active");
   AST_BUSY_ACTIVE: assert property (core_busy |-> !standby)
      else $error("standby during a core cycle");
   AST_STANDBY: assert property ((pins.sel_n && !core_busy) [*5]
      |-> standby && !active_pwr)
      else $error("idle device not in standby");
   AST_OUT_ON_FALL: assert property ($changed(miso_o) && !miso_oe_n
      && $past(!miso_oe_n) |-> !$past(pins.sclk, 2))
      else $error("output moved after a rising clock");
   AST_WR_PULSE: assert property (req.wr |=> !req.wr)
      else $error("write request longer than one cycle");
   AST_ONE_KIND: assert property ($onehot0({req.wr, req.rd,
      req.wipe_sect, req.wipe_all}))
      else $error("two request kinds at once");
endmodule : sfe_front_end_chk

bind sfe_front_end sfe_front_end_chk i_sfe_front_end_chk (
   .ref_clk(ref_clk), .arst_n(arst_n), .pins(pins),
   .core_busy(core_busy), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
   .req(req), .active_pwr(active_pwr), .standby(standby));

`default_nettype wire

// >>> tb/test_sfe_front_end.sv
// Self-checking bench for the flash front end.
`timescale 1ns/1ps
`default_nettype none

module test_sfe_front_end;
   import sfe_pkg::*;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic core_busy = 1'b0;
   logic [7:0] core_rdata = 8'ha5;
   logic miso_o, miso_oe_n, active_pwr, standby;
   logic [7:0] rb; // Last byte the master read.
   sfe_pins_t pins;
   sfe_req_t req;
   sfe_req_t req_q[$]; // Request pulses seen by the core.
   int bad_count = 0;
   int num_checks = 0;

   initial forever #2 ref_clk = ~ref_clk;

   sfe_front_end i_sfe_front_end (.ref_clk(ref_clk), .arst_n(arst_n),
      .pins(pins), .core_busy(core_busy), .core_rdata(core_rdata),
      .miso_o(miso_o), .miso_oe_n(miso_oe_n), .req(req),
      .active_pwr(active_pwr), .standby(standby));
   sfe_spi_master i_sfe_spi_master (.ref_clk(ref_clk), .miso_o(miso_o),
      .miso_oe_n(miso_oe_n), .pins(pins));

   // Queue every pulse so no one-cycle request is missed.
   always @(posedge ref_clk) begin
      if (req.wr || req.rd || req.wipe_sect || req.wipe_all) begin
         req_q.push_back(req);
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   task automatic chk_val(input string n, input logic [7:0] e,
                          input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_val

   // Oldest request: kind, address unless full wipe, data for writes.
   task automatic chk_req(input logic [3:0] k, input logic [17:0] a,
                          input logic [7:0] d);
      sfe_req_t g;
      num_checks++;
      for (int i = 0; i < 400 && req_q.size() == 0; i++) begin
         @(negedge ref_clk);
      end
      if (req_q.size() == 0) begin
         bad_count++;
         $display("ERROR request expected %h seen none", k);
         final_report();
      end else begin
         g = req_q.pop_front();
         if ({g.wr, g.rd, g.wipe_sect, g.wipe_all} !== k ||
             (!k[0] && g.addr !== a) || (k[3] && g.wdata !== d)) begin
            bad_count++;
            $display("ERROR request expected %h seen %h", {k, a, d}, g);
         end
      end
   endtask : chk_req

   // Opcode, three address bytes unless full wipe, then n data bytes from 8'h3c up.
   task automatic frame(input logic pol, input logic [7:0] op,
                        input logic [23:0] a, input int n, input int pb);
      i_sfe_spi_master.start(pol);
      i_sfe_spi_master.xfer(op, -1, rb);
      // A full wipe is the opcode alone; any further byte cancels it.
      if (op != SFE_OP_FULL_WIPE) begin
         for (int i = 2; i >= 0; i--) begin
            i_sfe_spi_master.xfer(a[8*i+:8], -1, rb);
         end
      end
      for (int i = 0; i < n; i++) begin
         i_sfe_spi_master.xfer(8'h3c + 8'(i), pb, rb);
      end
      i_sfe_spi_master.stop();
   endtask : frame

   // A frame with select low since power-up must be ignored.
   task automatic t_early();
      frame(1'b0, SFE_OP_PAGE_WRITE, 24'h000000, 1, -1);
      chk_val("early requests", 8'h00, 8'(req_q.size()));
   endtask : t_early

   // Page write from the last byte of a page, paused in each data byte.
   task automatic t_write();
      frame(1'b0, SFE_OP_PAGE_WRITE, 24'h0123ff, 2, 3);
      chk_req(4'b1000, 18'h123ff, 8'h3c);
      chk_req(4'b1000, 18'h12300, 8'h3d);
   endtask : t_write

   // Both erase granularities.
   task automatic t_wipes();
      frame(1'b0, SFE_OP_BLOCK_WIPE, 24'h020000, 0, -1);
      chk_req(4'b0010, 18'h20000, 8'h00);
      frame(1'b0, SFE_OP_FULL_WIPE, 24'h000000, 0, -1);
      chk_req(4'b0001, 18'h00000, 8'h00);
   endtask : t_wipes

   // Read one byte with the clock idling low, then high.
   task automatic t_read();
      for (int p = 0; p < 2; p++) begin
         core_rdata = p[0] ? 8'h5a : 8'ha5;
         frame(p[0], SFE_OP_READ, 24'h030010, 1, -1);
         chk_val("read byte", core_rdata, rb);
         chk_req(4'b0100, 18'h30010, 8'h00);
         chk_req(4'b0100, 18'h30011, 8'h00);
         req_q.delete();
      end
   endtask : t_read

   // A core cycle keeps a deselected device active.
   task automatic t_power();
      core_busy = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk_val("active", 8'h01, {7'h00, active_pwr});
      core_busy = 1'b0;
      repeat (6) @(negedge ref_clk);
      chk_val("standby", 8'h01, {7'h00, standby});
      i_sfe_spi_master.start(1'b0);
      chk_val("selected", 8'h01, {7'h00, active_pwr});
      i_sfe_spi_master.stop();
   endtask : t_power

   initial begin
      repeat (5) @(negedge ref_clk);
      arst_n = 1'b1;
      t_early();
      t_write();
      t_wipes();
      t_read();
      t_power();
      final_report();
   end
endmodule : test_sfe_front_end

`default_nettype wire
